// ---- verilog/comparator_block.sv ----
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/10ps
module comparator_block
  import comp_pkg::*;
(
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog front end
  input wire logic [NUM_CMP-1:0] vn_below_vp,
  output analog_ctrl_t [NUM_CMP-1:0] analog_ctrl,
  // Pins and port direction
  input wire logic port_a_direction_bit2,
  input wire logic port_c_direction_bit4,
  output logic first_pin_out,
  output logic first_pin_oe,
  output logic second_pin_out,
  output logic second_pin_oe,
  // Timer
  input wire logic timer_clock,
  input wire logic prescaler_active,
  input wire logic prescaler_out,
  input wire logic timer_gate_pin,
  output logic timer_gate,
  output logic timer_count_tick,
  // Interrupt
  output logic comparator_irq_request
);
  main_state_t st;
  main_state_t nxt;
  logic setup;
  logic access;
  logic wr;
  logic hit;
  logic cycle_end;
  logic synced_second_result;
  logic [NUM_CMP-1:0] live;
  logic [NUM_CMP-1:0] latched;
  logic [NUM_CMP-1:0] change;
  logic [NUM_CMP-1:0] refresh;
  logic [7:0] rd_value;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite;
  assign cycle_end = (st.phase == PHASE_Q4);
  assign hit = (paddr == OFS_FIRST_CTRL) | (paddr == OFS_SECOND_CTRL) |
               (paddr == OFS_MIRROR) | (paddr == OFS_FLAG) |
               (paddr == OFS_ENABLE) | (paddr == OFS_INTCTL);

  // Zero-wait slave; read data is captured in the setup cycle
  assign pready = access;
  assign pslverr = access & ~hit;
  assign prdata = {24'h000000, st.rdata};

  for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
    // Any access to the own control register, read or write; never the mirror
    assign refresh[i] = access &
      (paddr == ((i == 0) ? OFS_FIRST_CTRL : OFS_SECOND_CTRL));
    assign analog_ctrl[i] = '{st.ctrl[i].on, st.ctrl[i].speed,
                              st.ctrl[i].refsel, st.ctrl[i].chan};

    comp_channel u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .vn_below_vp(vn_below_vp[i]),
      .comparator_on(st.ctrl[i].on),
      .polarity_invert(st.ctrl[i].pol),
      .cycle_end(cycle_end),
      .refresh(refresh[i]),
      .live_result(live[i]),
      .latched_result(latched[i]),
      .change_event(change[i])
    );
  end

  second_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .timer_clock(timer_clock),
    .prescaler_active(prescaler_active),
    .prescaler_out(prescaler_out),
    .sync_enable(st.sync_en),
    .result_in(live[1]),
    .synced_result(synced_second_result),
    .count_tick(timer_count_tick)
  );

  // Pin path bypasses the latch so external edges keep analog timing
  assign first_pin_out = live[0];
  assign first_pin_oe = st.ctrl[0].oe & st.ctrl[0].on & ~port_a_direction_bit2;
  assign second_pin_out = live[1];
  assign second_pin_oe = st.ctrl[1].oe & st.ctrl[1].on & ~port_c_direction_bit4;

  assign timer_gate = st.gate_sel ? timer_gate_pin : synced_second_result;

  assign comparator_irq_request = st.global_en & st.periph_en &
                                  (|(st.flags & st.irq_en));

  always_comb begin
    rd_value = 8'h00;
    case (paddr)
      OFS_FIRST_CTRL: begin
        rd_value = st.ctrl[0];
        rd_value[CTL_RESULT] = latched[0];
      end
      OFS_SECOND_CTRL: begin
        rd_value = st.ctrl[1];
        rd_value[CTL_RESULT] = latched[1];
      end
      OFS_MIRROR: begin
        rd_value[MIR_FIRST] = latched[0];
        rd_value[MIR_SECOND] = latched[1];
        rd_value[MIR_GATE_SEL] = st.gate_sel;
        rd_value[MIR_SYNC] = st.sync_en;
      end
      OFS_FLAG: begin
        rd_value[FLAG_LSB +: NUM_CMP] = st.flags;
      end
      OFS_ENABLE: begin
        rd_value[FLAG_LSB +: NUM_CMP] = st.irq_en;
      end
      OFS_INTCTL: begin
        rd_value[INT_GLOBAL] = st.global_en;
        rd_value[INT_PERIPH] = st.periph_en;
      end
      default: begin
        rd_value = 8'h00;
      end
    endcase
  end

  always_comb begin
    nxt = st;
    case (st.phase)
      PHASE_Q1: nxt.phase = PHASE_Q2;
      PHASE_Q2: nxt.phase = PHASE_Q3;
      PHASE_Q3: nxt.phase = PHASE_Q4;
      PHASE_Q4: nxt.phase = PHASE_Q1;
      default: nxt.phase = PHASE_Q1;
    endcase
    if (setup) begin
      nxt.rdata = rd_value;
    end
    if (wr && paddr == OFS_FIRST_CTRL) begin
      nxt.ctrl[0] = pwdata[7:0];
      nxt.ctrl[0].result = 1'b0;
    end
    if (wr && paddr == OFS_SECOND_CTRL) begin
      nxt.ctrl[1] = pwdata[7:0];
      nxt.ctrl[1].result = 1'b0;
    end
    if (wr && paddr == OFS_MIRROR) begin
      nxt.gate_sel = pwdata[MIR_GATE_SEL];
      nxt.sync_en = pwdata[MIR_SYNC];
    end
    if (wr && paddr == OFS_ENABLE) begin
      nxt.irq_en = pwdata[FLAG_LSB +: NUM_CMP];
    end
    if (wr && paddr == OFS_INTCTL) begin
      nxt.global_en = pwdata[INT_GLOBAL];
      nxt.periph_en = pwdata[INT_PERIPH];
    end
    // A change event wins over a clearing write in the same cycle
    if (wr && paddr == OFS_FLAG) begin
      nxt.flags = pwdata[FLAG_LSB +: NUM_CMP];
    end
    nxt.flags = nxt.flags | change;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= MAIN_RESET;
    end else begin
      st <= nxt;
    end
  end

  AST_CYCLE_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
    cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("instruction cycle is not four clocks");
  AST_PIN_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    first_pin_oe |-> st.ctrl[0].on && !port_a_direction_bit2 &&
      first_pin_out == (vn_below_vp[0] ^ st.ctrl[0].pol))
    else $error("first pin driven without its conditions");
  AST_FLAG_ON_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
    change[0] |=> st.flags[0])
    else $error("change event did not set flag");
  AST_WRITE_ONE_SETS: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_FLAG && pwdata[FLAG_LSB + 1] |=> st.flags[1])
    else $error("written one did not set flag");
  AST_WRITE_ZERO_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_FLAG && !pwdata[FLAG_LSB] && !change[0] |=> !st.flags[0])
    else $error("written zero did not clear flag");
  AST_IRQ_NEEDS_ENABLES: assert property (@(posedge pclk) disable iff (!presetn)
    comparator_irq_request |-> st.global_en && st.periph_en && (|(st.flags & st.irq_en)))
    else $error("request without all enables");
  AST_MIRROR_NO_REFRESH: assert property (@(posedge pclk) disable iff (!presetn)
    access && paddr == OFS_MIRROR |-> refresh == 2'b00)
    else $error("mirror access refreshed mismatch latch");
  AST_MIRROR_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && $past(setup) && paddr == OFS_MIRROR |->
      prdata[5:2] == 4'h0 && prdata[7] == $past(latched[0]))
    else $error("mirror read data wrong");
  AST_GATE_FROM_SYNC: assert property (@(posedge pclk) disable iff (!presetn)
    !st.gate_sel |-> timer_gate == synced_second_result)
    else $error("timer gate not from synced result");
  AST_UNMAPPED_ERROR: assert property (@(posedge pclk) disable iff (!presetn)
    access && !hit |-> pslverr && pready)
    else $error("unmapped access not flagged");
  AST_SECOND_PIN_GATED: assert property (@(posedge pclk) disable iff (!presetn)
    second_pin_oe |-> st.ctrl[1].oe && !port_c_direction_bit4)
    else $error("second pin driven without its conditions");
  AST_GATE_FROM_PIN: assert property (@(posedge pclk) disable iff (!presetn)
    st.gate_sel |-> timer_gate == timer_gate_pin)
    else $error("timer gate not from gate pin");
  AST_FLAG_ON_SECOND_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
    change[1] |=> st.flags[1])
    else $error("second change event did not set flag");
endmodule

// ---- verilog/comp_pkg.sv ----
package comp_pkg;
  localparam int ADDR_W = 8;
  localparam int NUM_CMP = 2;
  localparam logic [ADDR_W-1:0] OFS_FIRST_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SECOND_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MIRROR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_INTCTL = 8'h14;
  localparam int CTL_RESULT = 6;
  localparam int MIR_FIRST = 7;
  localparam int MIR_SECOND = 6;
  localparam int MIR_GATE_SEL = 1;
  localparam int MIR_SYNC = 0;
  localparam int FLAG_LSB = 3;
  localparam int INT_GLOBAL = 7;
  localparam int INT_PERIPH = 6;
  localparam logic MIRROR_GATE_RESET = 1'b1;
  localparam logic MIRROR_SYNC_RESET = 1'b0;

  typedef struct packed {
    logic on;
    logic result;
    logic oe;
    logic pol;
    logic speed;
    logic refsel;
    logic [1:0] chan;
  } ctrl_t;
  localparam ctrl_t CTRL_RESET = 8'h00;

  typedef struct packed {
    logic on;
    logic speed;
    logic refsel;
    logic [1:0] chan;
  } analog_ctrl_t;

  typedef enum logic [1:0] {
    PHASE_Q1 = 2'b00,
    PHASE_Q2 = 2'b01,
    PHASE_Q3 = 2'b11,
    PHASE_Q4 = 2'b10
  } quarter_t;

  typedef struct packed {
    quarter_t phase;
    ctrl_t [NUM_CMP-1:0] ctrl;
    logic gate_sel;
    logic sync_en;
    logic [NUM_CMP-1:0] flags;
    logic [NUM_CMP-1:0] irq_en;
    logic periph_en;
    logic global_en;
    logic [7:0] rdata;
  } main_state_t;
  localparam main_state_t MAIN_RESET = '{PHASE_Q1, {CTRL_RESET, CTRL_RESET},
    MIRROR_GATE_RESET, MIRROR_SYNC_RESET, 2'b00, 2'b00, 1'b0, 1'b0, 8'h00};

  typedef struct packed {
    logic latched;
    logic store;
    logic mismatch_prev;
  } chan_state_t;

  typedef struct packed {
    logic clk_prev;
    logic held;
  } sync_state_t;
endpackage

// ---- verilog/comp_channel.sv ----
`timescale 1ns/10ps
module comp_channel
  import comp_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Analog and control
  input wire logic vn_below_vp,
  input wire logic comparator_on,
  input wire logic polarity_invert,
  input wire logic cycle_end,
  input wire logic refresh,
  // Results
  output logic live_result,
  output logic latched_result,
  output logic change_event
);
  chan_state_t st;
  chan_state_t nxt;
  logic mismatch;

  assign live_result = comparator_on & (vn_below_vp ^ polarity_invert);
  assign mismatch = st.latched != st.store;
  assign change_event = mismatch & ~st.mismatch_prev;
  assign latched_result = st.latched;

  always_comb begin
    nxt = st;
    if (cycle_end) begin
      nxt.latched = live_result;
    end
    // Taking the new value here loses a change that lands on the access
    if (refresh) begin
      nxt.store = cycle_end ? live_result : st.latched;
    end
    nxt.mismatch_prev = mismatch;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  AST_LATCH_AT_CYCLE_END: assert property (@(posedge pclk) disable iff (!presetn)
    cycle_end |=> latched_result == $past(live_result))
    else $error("latched result missed cycle end");
  AST_REFRESH_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
    refresh |=> !change_event)
    else $error("event right after refresh");
  AST_EDGE_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    change_event && !refresh |=> !change_event)
    else $error("event repeated on mismatch level");
endmodule

// ---- verilog/second_sync.sv ----
`timescale 1ns/10ps
module second_sync
  import comp_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Timer clock sources
  input wire logic timer_clock,
  input wire logic prescaler_active,
  input wire logic prescaler_out,
  // Result path
  input wire logic sync_enable,
  input wire logic result_in,
  output logic synced_result,
  output logic count_tick
);
  sync_state_t st;
  sync_state_t nxt;
  logic source;
  logic fall;

  assign source = prescaler_active ? prescaler_out : timer_clock;
  assign fall = st.clk_prev & ~source;
  assign count_tick = ~st.clk_prev & source;
  assign synced_result = sync_enable ? st.held : result_in;

  always_comb begin
    nxt = st;
    nxt.clk_prev = source;
    if (fall) begin
      nxt.held = result_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  AST_SYNC_ON_FALL: assert property (@(posedge pclk) disable iff (!presetn)
    fall ##1 sync_enable |-> synced_result == $past(result_in))
    else $error("synced result not taken on falling edge");
  AST_SYNC_HOLDS: assert property (@(posedge pclk) disable iff (!presetn)
    sync_enable && !fall ##1 sync_enable |-> $stable(synced_result))
    else $error("synced result moved without falling edge");
endmodule

// ---- tb/analog_timer_model.sv ----
`timescale 1ns/10ps
module analog_timer_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands from the bench
  input wire logic run,
  input wire logic use_presc,
  // Timer clock sources
  output logic timer_clock,
  output logic prescaler_active,
  output logic prescaler_out
);
  logic [2:0] div_reg;

  // Clocks stand still while run is low, so sync edges come only on demand
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 3'h0;
      timer_clock <= 1'b0;
      prescaler_out <= 1'b0;
    end else if (run) begin
      div_reg <= div_reg + 3'h1;
      if (div_reg == 3'h7) begin
        timer_clock <= ~timer_clock;
        if (!timer_clock) begin
          prescaler_out <= ~prescaler_out;
        end
      end
    end
  end
  assign prescaler_active = use_presc;
endmodule

// ---- tb/tb_comparator_output_interrupt_logic.sv ----
`timescale 1ns/10ps
module tb_comparator_output_interrupt_logic;
  import comp_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e; logic err;} row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] vn;
  analog_ctrl_t [NUM_CMP-1:0] analog_ctrl;
  logic dir_a, pin1, oe1, tclk, pact, pout, gate_pin, gate, tick, irq, run, use_presc, er;
  logic dir_c, pin2, oe2;
  int err_total, n_checks, cyc, ticks, t0;
  row_t rows[14] = '{
    '{1'b0, 8'h00, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h04, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h08, 8'h00, 8'h02, 1'b0}, '{1'b0, 8'h0c, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h10, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h14, 8'h00, 8'h00, 1'b0},
    '{1'b1, 8'h08, 8'hff, 8'h00, 1'b0}, '{1'b0, 8'h08, 8'h00, 8'h03, 1'b0},
    '{1'b1, 8'h0c, 8'h18, 8'h00, 1'b0}, '{1'b0, 8'h0c, 8'h00, 8'h18, 1'b0},
    '{1'b1, 8'h0c, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h0c, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h1c, 8'h00, 8'h00, 1'b1}, '{1'b1, 8'h1c, 8'hff, 8'h00, 1'b1}};

  comparator_block dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vn_below_vp(vn), .analog_ctrl(analog_ctrl),
    .port_a_direction_bit2(dir_a), .port_c_direction_bit4(dir_c), .first_pin_out(pin1),
    .first_pin_oe(oe1), .second_pin_out(pin2), .second_pin_oe(oe2), .timer_clock(tclk),
    .prescaler_active(pact), .prescaler_out(pout), .timer_gate_pin(gate_pin),
    .timer_gate(gate), .timer_count_tick(tick), .comparator_irq_request(irq));
  analog_timer_model partner (.pclk(pclk), .presetn(presetn), .run(run),
    .use_presc(use_presc), .timer_clock(tclk), .prescaler_active(pact), .prescaler_out(pout));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (tick === 1'b1) ticks++;
    if (cyc == 6000) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, e});
  endtask
  task automatic step(input logic v, input logic [7:0] ef);
    vn[0] <= v;
    repeat (12) @(posedge pclk);
    rreg(OFS_FLAG, ef);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    logic [2:0] k;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {vn, dir_a, dir_c, gate_pin, run, use_presc} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(er, rows[i].err);
      if (!rows[i].w) chk(rd, {24'h0, rows[i].e});
    end
    $display("register table test done");
    // Refresh the mismatch latch and clear flags before any enable
    wreg(OFS_FIRST_CTRL, 8'ha0);
    rreg(OFS_FIRST_CTRL, 8'ha0);
    wreg(OFS_FLAG, 8'h00);
    step(1'b1, 8'h08);
    rreg(OFS_MIRROR, 8'h83);
    wreg(OFS_FLAG, 8'h00);
    step(1'b0, 8'h00);
    step(1'b1, 8'h08);
    rreg(OFS_FIRST_CTRL, 8'he0);
    wreg(OFS_FLAG, 8'h00);
    step(1'b0, 8'h08);
    chk(irq, 1'b0);
    wreg(OFS_ENABLE, 8'h08);
    wreg(OFS_INTCTL, 8'hc0);
    @(negedge pclk);
    chk(irq, 1'b1);
    wreg(OFS_INTCTL, 8'h40);
    @(negedge pclk);
    chk(irq, 1'b0);
    // Pin output disabled: flags must still follow the comparator
    wreg(OFS_FIRST_CTRL, 8'h80);
    wreg(OFS_FLAG, 8'h00);
    step(1'b1, 8'h08);
    $display("interrupt test done");
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      wreg(OFS_FIRST_CTRL, {3'b101, k[1], 4'h0});
      vn[0] <= k[0];
      dir_a <= k[2];
      @(negedge pclk);
      chk(pin1, k[0] ^ k[1]);
      chk(oe1, !k[2]);
    end
    wreg(OFS_FIRST_CTRL, 8'h30);
    dir_a <= 1'b0;
    @(negedge pclk);
    chk(oe1, 1'b0);
    chk(pin1, 1'b0);
    wreg(OFS_FIRST_CTRL, 8'h8d);
    @(negedge pclk);
    chk(analog_ctrl[0], 5'b11101);
    wreg(OFS_SECOND_CTRL, 8'h0a);
    @(negedge pclk);
    chk(analog_ctrl[1], 5'b01010);
    $display("pin and control test done");
    wreg(OFS_SECOND_CTRL, 8'h80);
    wreg(OFS_MIRROR, 8'h00);
    vn[1] <= 1'b1;
    @(negedge pclk);
    chk(gate, 1'b1);
    chk(pin2, 1'b1);
    chk(oe2, 1'b0);
    wreg(OFS_MIRROR, 8'h02);
    @(negedge pclk);
    chk(gate, 1'b0);
    @(posedge pclk);
    gate_pin <= 1'b1;
    @(negedge pclk);
    chk(gate, 1'b1);
    // Comparator gates the timer, so sync is switched on
    wreg(OFS_MIRROR, 8'h01);
    run <= 1'b1;
    repeat (40) @(posedge pclk);
    run <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      @(posedge pclk);
      use_presc <= p[0];
      wreg(OFS_MIRROR, 8'h01);
      vn[1] <= p[0];
      @(negedge pclk);
      chk(gate, !p[0]);
      t0 = ticks;
      @(posedge pclk);
      run <= 1'b1;
      repeat (80) @(posedge pclk);
      run <= 1'b0;
      @(negedge pclk);
      chk(gate, p[0]);
      chk(p ? (ticks - t0 <= 3) : (ticks - t0 >= 4), 1'b1);
    end
    $display("sync test done");
    wreg(OFS_SECOND_CTRL, 8'hb0);
    @(negedge pclk);
    chk(pin2, 1'b0);
    chk(oe2, 1'b1);
    @(posedge pclk);
    dir_c <= 1'b1;
    @(negedge pclk);
    chk(oe2, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rreg(OFS_FIRST_CTRL, 8'h00);
    rreg(OFS_MIRROR, 8'h02);
    rreg(OFS_FLAG, 8'h00);
    $display("second reset test done");
    wrap_up();
  end
endmodule
